// ==== cbim_top.sv ====
// Purpose: cell-balance event flags, mask register and interrupt pin drive
// Assumes: simple register port (addr, wr, rd, wdata) from the serial slave
// Notes:   flags clear on read; mask only gates the pin
`timescale 1ns/1ps
module cbim_top
  import cbim_pkg::*;
#(
  parameter int NSRC = cbim_pkg::CBIM_NSRC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       balance_active,
  input  wire logic       upper_cv,
  input  wire logic       lower_cv,
  input  wire logic       upper_overvolt,
  input  wire logic       lower_overvolt,
  input  wire logic       balance_overcurrent,
  output logic            int_n
);
  // refused at elaboration: the source map below is wired for exactly six
  if (NSRC != CBIM_NSRC) begin : g_nsrc_check
    $error("cbim_top supports exactly six sources");
  end

  logic [5:0] src_async;
  logic [5:0] src_s;
  logic       bal_prev_q;
  logic [5:0] flag_q;
  logic [5:0] flag_d;
  logic [5:0] mask_q;
  logic [5:0] mask_d;
  logic [5:0] event_w;
  logic [5:0] rd_clr_w;
  logic       flag_rd_w;
  logic       hit_mask;
  logic       hit_flag;
  logic [7:0] rdata_d;
  logic       int_n_d;

  assign src_async = {balance_active, upper_cv, lower_cv,
                      upper_overvolt, lower_overvolt, balance_overcurrent};

  cbim_sync #(.W(6)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (src_async),
    .sync_out (src_s)
  );

  assign hit_mask = (reg_addr == CBIM_MASK_ADDR);
  assign hit_flag = (reg_addr == CBIM_FLAG_ADDR);

  // balance source is an edge (either way); the others are levels
  assign event_w[CBIM_BIT_BAL] = src_s[CBIM_BIT_BAL] ^ bal_prev_q;
  assign event_w[4:0]          = src_s[4:0];

  assign flag_rd_w = reg_rd && hit_flag;
  assign rd_clr_w  = flag_rd_w ? 6'h3f : 6'h00;
  // set wins over clear so an event in the read cycle is kept
  assign flag_d = (flag_q & ~rd_clr_w) | event_w;

  assign mask_d = (reg_wr && hit_mask) ? (reg_wdata[5:0] & CBIM_MASK_WMASK[5:0])
                                       : mask_q;

  assign rdata_d = hit_mask ? {2'b00, mask_q} :
                   hit_flag ? {2'b00, flag_q} : 8'h00;

  // pin follows unmasked pending flags; masking never touches the flag
  assign int_n_d = ~|(flag_d & ~mask_d);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_q     <= CBIM_MASK_RESET[5:0];
      flag_q     <= CBIM_FLAG_RESET[5:0];
      bal_prev_q <= 1'b0;
      reg_rdata  <= 8'h00;
      int_n      <= 1'b1;
    end else begin
      mask_q     <= mask_d;
      flag_q     <= flag_d;
      bal_prev_q <= src_s[CBIM_BIT_BAL];
      reg_rdata  <= rdata_d;
      int_n      <= int_n_d;
    end
  end

  sequence s_bal_edge;
    src_s[CBIM_BIT_BAL] != bal_prev_q;
  endsequence

  property p_mask_reads_low;
    @(posedge clock) disable iff (!rst_n)
      reg_rd && hit_mask |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == $past(mask_q);
  endproperty
  a_mask_reads_low: assert property (p_mask_reads_low) else $error("mask readback wrong");

  property p_mask_write;
    @(posedge clock) disable iff (!rst_n)
      reg_wr && hit_mask |=> mask_q == $past(reg_wdata[5:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_all_masked_quiet;
    @(posedge clock) disable iff (!rst_n)
      mask_d == 6'h3f |=> int_n;
  endproperty
  a_all_masked_quiet: assert property (p_all_masked_quiet) else $error("pin low while masked");

  property p_bal_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h20 && mask_d[CBIM_BIT_BAL]) |=> int_n;
  endproperty
  a_bal_masked: assert property (p_bal_masked) else $error("balance event not masked");

  property p_ucv_unmasked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d[CBIM_BIT_UCV] && !mask_d[CBIM_BIT_UCV]) |=> !int_n;
  endproperty
  a_ucv_unmasked: assert property (p_ucv_unmasked) else $error("pin not asserted");

  property p_bal_edge_flag;
    @(posedge clock) disable iff (!rst_n)
      s_bal_edge |=> flag_q[CBIM_BIT_BAL];
  endproperty
  a_bal_edge_flag: assert property (p_bal_edge_flag) else $error("balance flag missed");

  property p_flag_sticky;
    @(posedge clock) disable iff (!rst_n)
      flag_q[CBIM_BIT_LOV] && !(reg_rd && hit_flag) |=> flag_q[CBIM_BIT_LOV];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped early");

  property p_masked_recorded;
    @(posedge clock) disable iff (!rst_n)
      src_s[CBIM_BIT_BOC] && mask_q[CBIM_BIT_BOC] |=> flag_q[CBIM_BIT_BOC];
  endproperty
  a_masked_recorded: assert property (p_masked_recorded) else $error("masked event lost");

  sequence s_read_no_event;
    flag_rd_w && (event_w == 6'h00);
  endsequence

  sequence s_read_with_level;
    flag_rd_w && event_w[CBIM_BIT_UOV];
  endsequence

  property p_reset_values;
    @(posedge clock)
      !rst_n |=> int_n && reg_rdata == 8'h00 && mask_q == CBIM_MASK_RESET[5:0]
                 && flag_q == CBIM_FLAG_RESET[5:0];
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_ucv_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h10 && mask_d[CBIM_BIT_UCV]) |=> int_n;
  endproperty
  a_ucv_masked: assert property (p_ucv_masked) else $error("upper cv event not masked");

  property p_lcv_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h08 && mask_d[CBIM_BIT_LCV]) |=> int_n;
  endproperty
  a_lcv_masked: assert property (p_lcv_masked) else $error("lower cv event not masked");

  property p_uov_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h04 && mask_d[CBIM_BIT_UOV]) |=> int_n;
  endproperty
  a_uov_masked: assert property (p_uov_masked) else $error("upper ov event not masked");

  property p_lov_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h02 && mask_d[CBIM_BIT_LOV]) |=> int_n;
  endproperty
  a_lov_masked: assert property (p_lov_masked) else $error("lower ov event not masked");

  property p_boc_masked;
    @(posedge clock) disable iff (!rst_n)
      (flag_d == 6'h01 && mask_d[CBIM_BIT_BOC]) |=> int_n;
  endproperty
  a_boc_masked: assert property (p_boc_masked) else $error("overcurrent event not masked");

  property p_any_unmasked;
    @(posedge clock) disable iff (!rst_n)
      (|(flag_d & ~mask_d)) |=> !int_n;
  endproperty
  a_any_unmasked: assert property (p_any_unmasked) else $error("unmasked event silent");

  property p_read_clears;
    @(posedge clock) disable iff (!rst_n)
      s_read_no_event |=> flag_q == 6'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");

  property p_set_wins;
    @(posedge clock) disable iff (!rst_n)
      s_read_with_level |=> flag_q[CBIM_BIT_UOV];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in read cycle");

  property p_flag_readback;
    @(posedge clock) disable iff (!rst_n)
      flag_rd_w |=> reg_rdata == {2'b00, $past(flag_q)};
  endproperty
  a_flag_readback: assert property (p_flag_readback) else $error("flag readback wrong");

  property p_mask_hold;
    @(posedge clock) disable iff (!rst_n)
      !(reg_wr && hit_mask) |=> mask_q == $past(mask_q);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");
endmodule : cbim_top

// ==== cbim_pkg.sv ====
// Purpose: constants for the cell-balance interrupt mask block
// Assumes: 8-bit register port, one clock domain
// Notes:   bit positions shared by mask and flag registers
package cbim_pkg;
  localparam logic [7:0] CBIM_MASK_ADDR  = 8'h2c;
  localparam logic [7:0] CBIM_FLAG_ADDR  = 8'h2b;
  localparam logic [7:0] CBIM_MASK_RESET = 8'h00;
  localparam logic [7:0] CBIM_FLAG_RESET = 8'h00;
  localparam logic [7:0] CBIM_MASK_WMASK = 8'h3f;
  localparam int         CBIM_NSRC       = 6;
  localparam int         CBIM_BIT_BAL    = 5;
  localparam int         CBIM_BIT_UCV    = 4;
  localparam int         CBIM_BIT_LCV    = 3;
  localparam int         CBIM_BIT_UOV    = 2;
  localparam int         CBIM_BIT_LOV    = 1;
  localparam int         CBIM_BIT_BOC    = 0;
endpackage : cbim_pkg

// ==== cbim_sync.sv ====
// Purpose: two-flop synchroniser for a vector of event levels
// Assumes: inputs come from analog comparators outside the clock domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module cbim_sync #(
  parameter int W = 6
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : cbim_sync

// ==== cbim_host.sv ====
// Purpose: host model issuing register cycles
// Assumes: one strobe cycle per access
// Notes:   wdata inverted once released, never left at its last value
`timescale 1ns/1ps
module cbim_host (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock);
    #2;
    reg_addr = a;
    reg_wr = w;
    reg_rd = ~w;
    reg_wdata = d;
    @(posedge clock);
    #2;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask : access
endmodule : cbim_host

// ==== tb_cbim_top.sv ====
// Purpose: self-checking bench for cbim_top
// Assumes: host model drives the register port
// Notes:   events are held as levels long enough to cross the synchroniser
`timescale 1ns/1ps
module tb_cbim_top;
  import cbim_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  ev    = 6'h00;
  logic [7:0]  a, w, q, r;
  logic        wr, rd, int_n;
  logic [12:0] rows [12];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #12.5 clock = ~clock;
  cbim_host i_cbim_host (.clock(clock), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(w), .reg_rdata(q));
  cbim_top i_cbim_top (.clock(clock), .rst_n(rst_n), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(w), .reg_rdata(q), .balance_active(ev[5]), .upper_cv(ev[4]), .lower_cv(ev[3]),
    .upper_overvolt(ev[2]), .lower_overvolt(ev[1]), .balance_overcurrent(ev[0]),
    .int_n(int_n));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // bounded run: a hung handshake would otherwise stall forever
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    for (int i = 0; i < 6; i++) begin
      rows[2*i]   = {6'(1 << i), 6'(1 << i), 1'b1};
      rows[2*i+1] = {6'h3f ^ 6'(1 << i), 6'(1 << i), 1'b0};
    end
    step(16);
    chk({7'h00, int_n}, 8'h01);
    rst_n = 1'b1;
    i_cbim_host.access(1'b0, CBIM_MASK_ADDR, 8'h00, r);
    chk(r, CBIM_MASK_RESET);
    i_cbim_host.access(1'b1, CBIM_MASK_ADDR, 8'hff, r);
    i_cbim_host.access(1'b0, CBIM_MASK_ADDR, 8'h00, r);
    chk(r, 8'h3f);
    i_cbim_host.access(1'b1, 8'h40, 8'h5a, r);
    i_cbim_host.access(1'b0, 8'h40, 8'h00, r);
    chk(r, 8'h00);
    i_cbim_host.access(1'b0, CBIM_MASK_ADDR, 8'h00, r);
    chk(r, 8'h3f);
    foreach (rows[k]) begin
      i_cbim_host.access(1'b1, CBIM_MASK_ADDR, {2'b00, rows[k][12:7]}, r);
      ev = rows[k][6:1];
      step(6);
      chk({7'h00, int_n}, {7'h00, rows[k][0]});
      ev = 6'h00;
      step(6);
      i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
      chk(r, {2'b00, rows[k][6:1]});
      step(2);
      chk({7'h00, int_n}, 8'h01);
      i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
      chk(r, 8'h00);
    end
    // balance is an edge source: entry and exit set the flag, a steady level does not
    ev = 6'h20;
    step(6);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h20);
    step(2);
    chk({7'h00, int_n}, 8'h01);
    ev = 6'h00;
    step(6);
    chk({7'h00, int_n}, 8'h00);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h20);
    // a level held through the read is set again in that cycle
    ev = 6'h04;
    step(6);
    chk({7'h00, int_n}, 8'h01);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h04);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h04);
    i_cbim_host.access(1'b1, CBIM_MASK_ADDR, 8'h00, r);
    chk({7'h00, int_n}, 8'h00);
    ev = 6'h00;
    step(6);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h04);
    step(2);
    chk({7'h00, int_n}, 8'h01);
    // flag register ignores writes
    i_cbim_host.access(1'b1, CBIM_FLAG_ADDR, 8'hff, r);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, 8'h00);
    // mid-run reset with an unmasked event pending
    i_cbim_host.access(1'b1, CBIM_MASK_ADDR, 8'h15, r);
    ev = 6'h02;
    step(6);
    chk({7'h00, int_n}, 8'h00);
    rst_n = 1'b0;
    ev = 6'h00;
    step(4);
    chk({7'h00, int_n}, 8'h01);
    rst_n = 1'b1;
    step(1);
    chk({7'h00, int_n}, 8'h01);
    i_cbim_host.access(1'b0, CBIM_MASK_ADDR, 8'h00, r);
    chk(r, CBIM_MASK_RESET);
    i_cbim_host.access(1'b0, CBIM_FLAG_ADDR, 8'h00, r);
    chk(r, CBIM_FLAG_RESET);
    wrap_up();
  end
endmodule : tb_cbim_top
